// [fesp_regs.vh]
`ifndef FESP_REGS_VH
`define FESP_REGS_VH
// word offsets (byte addresses)
`define FESP_PEC_OFF 4'h0
`define FESP_PES_OFF 4'h4
`define FESP_EAS_OFF 4'h8
`define FESP_FPC_OFF 4'hC
// access enable register sits in a separate decode slot
`define FESP_FRAE_OFF 5'h10
`define FESP_ADDR_W 5
// program_erase_control fields
`define FESP_PEC_SWE 6
`define FESP_PEC_ESU 5
`define FESP_PEC_PSU 4
`define FESP_PEC_EV 3
`define FESP_PEC_PV 2
`define FESP_PEC_E 1
`define FESP_PEC_P 0
// erase_area_select fields
`define FESP_EAS_W 5
`define FESP_EAS_LARGE 4
// power control and access enable bit
`define FESP_TOP_BIT 7
`define FESP_RST8 8'h00
`define FESP_RST5 5'h00
`define FESP_RST7 7'h00
`define FESP_RST32 32'h00000000
`define FESP_ADDR0 16'h0000
// erase regions: base and last address, 16-bit
`define FESP_LARGE_BASE 16'h1000
`define FESP_LARGE_END_BIG 16'h7FFF
`define FESP_LARGE_END_SMALL 16'h3FFF
`define FESP_B3_BASE 16'h0C00
`define FESP_B3_END 16'h0FFF
`define FESP_B2_BASE 16'h0800
`define FESP_B2_END 16'h0BFF
`define FESP_B1_BASE 16'h0400
`define FESP_B1_END 16'h07FF
`define FESP_B0_BASE 16'h0000
`define FESP_B0_END 16'h03FF
`endif

// [fesp_flash_ctrl.v]
// The register offsets and register access over Wishbone were chosen for this implementation.
`timescale 1ns/1ps
`include "fesp_regs.vh"

// What this block does
// (R1) erase select held zero while write disabled
// (R2) more than one select bit clears all
// (R3) reserved bits always read zero
// (R4) large variant: block4 erases 0x1000-0x7FFF
// (R5) small variant: block4 erases 0x1000-0x3FFF
// (R6) block3 erases 0x0C00-0x0FFF
// (R7) block2 erases 0x0800-0x0BFF
// (R8) block1 erases 0x0400-0x07FF
// (R9) block0 erases 0x0000-0x03FF
// (R10) disable zero: subactive enters flash power-down
// (R11) disable one: flash stays normal in subactive
// (R12) control registers reachable only when enabled
// (R13) write enable zero refuses other bit sets
// (R14) erase mode needs erase, setup, write enable
// (R15) disabled: gated reads zero, writes ignored
module fesp_flash_ctrl #(
	parameter LARGE_VARIANT = 1
) (
	input wire clk_i,
	input wire rst_i,
	input wire cyc_i,
	input wire stb_i,
	input wire we_i,
	input wire [`FESP_ADDR_W-1:0] adr_i,
	input wire [3:0] sel_i,
	input wire [31:0] dat_i,
	input wire subactive_i,
	input wire flash_error_i,
	output reg [31:0] dat_o,
	output reg ack_o,
	output reg erase_mode_o,
	output reg program_mode_o,
	output reg [15:0] erase_base_o,
	output reg [15:0] erase_end_o,
	output reg erase_area_valid_o,
	output reg power_down_o
);
	reg [6:0] pec_reg;
	reg [6:0] pec_next;
	reg [`FESP_EAS_W-1:0] eas_reg;
	reg [`FESP_EAS_W-1:0] eas_next;
	reg pdd_reg;
	reg frae_reg;
	reg [31:0] rdata;
	reg [15:0] base_next;
	reg [15:0] end_next;
	reg valid_next;
	wire req;
	wire wr;
	wire hit_pec;
	wire hit_pes;
	wire hit_eas;
	wire hit_fpc;
	wire hit_frae;
	wire gated;
	wire [4:0] cnt;
	wire swe_now;
	wire [4:0] cnt_part [0:`FESP_EAS_W];
	wire wr_pec;
	wire wr_eas;
	wire wr_fpc;
	wire wr_frae;
	wire [31:0] rb_pec;
	wire [31:0] rb_pes;
	wire [31:0] rb_eas;
	wire [31:0] rb_fpc;
	wire [31:0] rb_frae;
	reg ack_next;
	reg [31:0] dat_next;
	reg [`FESP_EAS_W-1:0] eas_store;
	reg pdd_next;
	reg frae_next;
	reg erase_mode_next;
	reg program_mode_next;
	reg power_down_next;
	genvar gi;

	assign req = cyc_i & stb_i & ~ack_o;
	assign wr = req & we_i & sel_i[0];
	assign hit_pec = (adr_i == {1'b0, `FESP_PEC_OFF});
	assign hit_pes = (adr_i == {1'b0, `FESP_PES_OFF});
	assign hit_eas = (adr_i == {1'b0, `FESP_EAS_OFF});
	assign hit_fpc = (adr_i == {1'b0, `FESP_FPC_OFF});
	assign hit_frae = (adr_i == `FESP_FRAE_OFF);
	assign gated = frae_reg; // (R12)
	assign swe_now = pec_reg[`FESP_PEC_SWE];
	assign cnt_part[0] = 5'h00;
	// running count of set select bits
	generate
		for (gi = 0; gi < `FESP_EAS_W; gi = gi + 1) begin : g_cnt
			assign cnt_part[gi + 1] = cnt_part[gi] + {4'h0, eas_next[gi]};
		end
	endgenerate
	assign cnt = cnt_part[`FESP_EAS_W];

	// write strobes, all gated except wr_frae
	assign wr_pec = wr & hit_pec & gated; // (R15)
	assign wr_eas = wr & hit_eas & gated & swe_now; // (R13)
	assign wr_fpc = wr & hit_fpc & gated; // (R15)
	assign wr_frae = wr & hit_frae;

	// readback words, reserved bits zero
	assign rb_pec = {25'h0, pec_reg}; // (R3)
	assign rb_pes = {24'h0, flash_error_i, 7'h0};
	assign rb_eas = {27'h0, eas_reg}; // (R3)
	assign rb_fpc = {24'h0, pdd_reg, 7'h0}; // (R3)
	assign rb_frae = {24'h0, frae_reg, 7'h0}; // (R3)

	// program/erase control next value
	always @* begin
		pec_next = pec_reg;
		if (wr_pec) begin // (R15)
			pec_next[`FESP_PEC_SWE] = dat_i[`FESP_PEC_SWE];
			if (dat_i[`FESP_PEC_SWE] || swe_now) begin
				pec_next[5:0] = dat_i[5:0];
			end
			if (!dat_i[`FESP_PEC_SWE] && !swe_now) begin
				pec_next[5:0] = 6'h00; // (R13)
			end
		end
		if (!pec_next[`FESP_PEC_SWE]) begin
			pec_next[5:0] = 6'h00; // (R13)
		end
	end

	// erase select next value
	always @* begin
		eas_next = eas_reg;
		if (wr_eas) begin // (R13)
			eas_next = dat_i[`FESP_EAS_W-1:0];
		end
		if (!pec_next[`FESP_PEC_SWE]) begin
			eas_next = `FESP_RST5; // (R1)
		end
	end

	// erase region decode
	always @* begin
		base_next = 16'h0000;
		end_next = 16'h0000;
		valid_next = 1'b1;
		case (eas_reg)
			5'h10: begin
				base_next = `FESP_LARGE_BASE;
				if (LARGE_VARIANT != 0) begin
					end_next = `FESP_LARGE_END_BIG; // (R4)
				end else begin
					end_next = `FESP_LARGE_END_SMALL; // (R5)
				end
			end
			5'h08: begin
				base_next = `FESP_B3_BASE; // (R6)
				end_next = `FESP_B3_END;
			end
			5'h04: begin
				base_next = `FESP_B2_BASE; // (R7)
				end_next = `FESP_B2_END;
			end
			5'h02: begin
				base_next = `FESP_B1_BASE; // (R8)
				end_next = `FESP_B1_END;
			end
			5'h01: begin
				base_next = `FESP_B0_BASE; // (R9)
				end_next = `FESP_B0_END;
			end
			default: begin
				valid_next = 1'b0;
			end
		endcase
	end

	// read mux
	always @* begin
		rdata = 32'h00000000;
		if (hit_frae) begin
			rdata = rb_frae; // (R3)
		end else if (!gated) begin
			rdata = 32'h00000000; // (R15)
		end else if (hit_pec) begin
			rdata = rb_pec; // (R3)
		end else if (hit_pes) begin
			rdata = rb_pes;
		end else if (hit_eas) begin
			rdata = rb_eas; // (R3)
		end else if (hit_fpc) begin
			rdata = rb_fpc; // (R3)
		end
	end

	// bus answer: one-cycle registered ack
	always @* begin
		ack_next = req;
	end

	// read data taken on the request edge, held until the next one
	always @* begin
		dat_next = dat_o;
		if (req) begin
			dat_next = rdata;
		end
	end

	// multi-bit select write collapses to zero
	always @* begin
		eas_store = eas_next;
		if (cnt > 5'h01) begin
			eas_store = `FESP_RST5; // (R2)
		end
	end

	// power control register write
	always @* begin
		pdd_next = pdd_reg;
		if (wr_fpc) begin // (R15)
			pdd_next = dat_i[`FESP_TOP_BIT];
		end
	end

	// access enable register write, never gated
	always @* begin
		frae_next = frae_reg;
		if (wr_frae) begin
			frae_next = dat_i[`FESP_TOP_BIT]; // (R12)
		end
	end

	// erase mode request
	always @* begin
		erase_mode_next = pec_reg[`FESP_PEC_E] & pec_reg[`FESP_PEC_ESU] & swe_now; // (R14)
	end

	// program mode request
	always @* begin
		program_mode_next = pec_reg[`FESP_PEC_P] & pec_reg[`FESP_PEC_PSU] & swe_now;
	end

	// flash power-down in subactive mode
	always @* begin
		power_down_next = subactive_i & ~pdd_reg; // (R10) (R11)
	end

	// acknowledge register
	always @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
		end else begin
			ack_o <= ack_next;
		end
	end

	// read data register
	always @(posedge clk_i) begin
		if (rst_i) begin
			dat_o <= `FESP_RST32;
		end else begin
			dat_o <= dat_next;
		end
	end

	// control and select registers
	always @(posedge clk_i) begin
		if (rst_i) begin
			pec_reg <= `FESP_RST7;
			eas_reg <= `FESP_RST5;
		end else begin
			pec_reg <= pec_next;
			eas_reg <= eas_store;
		end
	end

	// power control and access enable registers
	always @(posedge clk_i) begin
		if (rst_i) begin
			pdd_reg <= 1'b0;
			frae_reg <= 1'b0;
		end else begin
			pdd_reg <= pdd_next;
			frae_reg <= frae_next;
		end
	end

	// mode and power outputs
	always @(posedge clk_i) begin
		if (rst_i) begin
			erase_mode_o <= 1'b0;
			program_mode_o <= 1'b0;
			power_down_o <= 1'b0;
		end else begin
			erase_mode_o <= erase_mode_next;
			program_mode_o <= program_mode_next;
			power_down_o <= power_down_next;
		end
	end

	// erase region outputs
	always @(posedge clk_i) begin
		if (rst_i) begin
			erase_base_o <= `FESP_ADDR0;
			erase_end_o <= `FESP_ADDR0;
			erase_area_valid_o <= 1'b0;
		end else begin
			erase_base_o <= base_next;
			erase_end_o <= end_next;
			erase_area_valid_o <= valid_next;
		end
	end
endmodule

// [fesp_flash_ctrl_assertions.sv]
`timescale 1ns/1ps
module fesp_chk (
	input wire clk_i,
	input wire rst_i,
	input wire cyc_i,
	input wire stb_i,
	input wire we_i,
	input wire [4:0] adr_i,
	input wire subactive_i,
	input wire [31:0] dat_o,
	input wire ack_o,
	input wire erase_mode_o,
	input wire [15:0] erase_base_o,
	input wire [15:0] erase_end_o,
	input wire erase_area_valid_o,
	input wire power_down_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_ack; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
	a_ack: assert property (p_ack) else $error("no ack");
	property p_one; ack_o |=> !ack_o; endproperty
	a_one: assert property (p_one) else $error("long ack");
	property p_rsv; ack_o && !$past(we_i) && $past(adr_i) == 5'h08 |-> dat_o[31:5] == 0; endproperty
	a_rsv: assert property (p_rsv) else $error("select reserved");
	property p_rsv2; ack_o && !$past(we_i) && $past(adr_i) inside {5'h0C, 5'h10}
		|-> dat_o[6:0] == 0; endproperty
	a_rsv2: assert property (p_rsv2) else $error("top reserved");
	property p_b3; erase_area_valid_o && erase_base_o == 16'h0C00 |-> erase_end_o == 16'h0FFF; endproperty
	a_b3: assert property (p_b3) else $error("block3 end");
	property p_b4; erase_area_valid_o && erase_base_o == 16'h1000 |-> erase_end_o == 16'h7FFF; endproperty
	a_b4: assert property (p_b4) else $error("large end");
	property p_nv; !erase_area_valid_o |-> erase_base_o == 0 && erase_end_o == 0; endproperty
	a_nv: assert property (p_nv) else $error("no region");
	property p_pd; !subactive_i |=> !power_down_o; endproperty
	a_pd: assert property (p_pd) else $error("power down");
	property p_em; $rose(erase_mode_o) |-> $past(ack_o); endproperty
	a_em: assert property (p_em) else $error("erase mode");
	c_em: cover property (erase_mode_o);
	c_pd: cover property (power_down_o);
	c_big: cover property (erase_area_valid_o && erase_base_o == 16'h1000);
endmodule
bind fesp_flash_ctrl fesp_chk i_chk (.*);

// [testbench.sv]
`timescale 1ns/1ps
module testbench;
	logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, sub_i = 0, fe = 0;
	logic [4:0] adr_i = 0;
	logic [31:0] dat_i = 0, q;
	wire [31:0] dat_o;
	wire [15:0] b, e;
	wire ack_o, em, v, pd, pm;
	int fails = 0, samples_checked = 0, r, pec = 0, eas = 0, fpc = 0, en = 0;
	initial forever #2.5 clk_i = ~clk_i;
	fesp_flash_ctrl #(.LARGE_VARIANT(1)) i_dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
		.sel_i(4'hF), .dat_i, .subactive_i(sub_i), .flash_error_i(fe), .dat_o, .ack_o,
		.erase_mode_o(em), .program_mode_o(pm), .erase_base_o(b), .erase_end_o(e),
		.erase_area_valid_o(v), .power_down_o(pd));
	task stop_test;
		$display("fails=%0d samples_checked=%0d", fails, samples_checked);
		if (fails == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task chk(input [31:0] g, input [31:0] x);
		samples_checked++;
		if (g !== x) begin
			fails++;
			$display("CHECK FAILED %0t got %h exp %h", $time, g, x);
		end
	endtask
	task bus(input [4:0] a, input w, input [7:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc_i <= 1;
		stb_i <= 1;
		we_i <= w;
		adr_i <= a;
		dat_i <= {24'h0, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 20);
		if (n >= 20) begin
			fails++;
			stop_test;
		end
		q = dat_o;
		cyc_i <= 0;
		stb_i <= 0;
	endtask
	// register model updated on each write
	task wr(input [4:0] a, input [7:0] d);
		bus(a, 1, d);
		if (a == 5'h10)
			en = d[7];
		else if (en && a == 0)
			pec = d[6] ? d[6:0] : 0;
		else if (en && a == 8)
			eas = (pec[6] && $countones(d[4:0]) == 1) ? d[4:0] : 0;
		else if (en && a == 12)
			fpc = d[7];
		if (!pec[6])
			eas = 0;
	endtask
	function int ex(input [4:0] a);
		case (a)
			0: return en ? pec : 0;
			4: return en ? {fe, 7'h0} : 0;
			8: return en ? eas : 0;
			12: return en ? fpc << 7 : 0;
			16: return en << 7;
			default: return 0;
		endcase
	endfunction
	function int rg(input int s);
		case (s)
			1: return 32'h000003FF;
			2: return 32'h040007FF;
			4: return 32'h08000BFF;
			8: return 32'h0C000FFF;
			16: return 32'h10007FFF;
			default: return 0;
		endcase
	endfunction
	task rd(input [4:0] a);
		bus(a, 0, 0);
		chk(q, ex(a));
	endtask
	initial begin
		r = $urandom(32'h813a);
		repeat (6) @(posedge clk_i);
		rst_i <= 0;
		rd(16);
		wr(8, 8'h01);
		rd(8);
		wr(16, 8'hFF);
		rd(16);
		fe <= 1;
		rd(4);
		wr(8, 8'h04);
		rd(8);
		wr(0, 8'h40);
		rd(0);
		for (int i = 0; i < 6; i++) begin
			wr(8, 8'h01 << i);
			rd(8);
			chk({b, e}, rg(eas));
		end
		wr(8, 8'h0A);
		rd(8);
		wr(0, 8'h62);
		repeat (2) @(posedge clk_i);
		chk(em, 1);
		wr(0, 8'h51);
		repeat (2) @(posedge clk_i);
		chk(pm, 1);
		chk(em, 0);
		wr(0, 8'h00);
		rd(8);
		chk(em, 0);
		sub_i <= 1;
		wr(12, 8'h80);
		rd(12);
		chk(pd, 0);
		r = $urandom;
		wr(12, r[7:0]);
		rd(12);
		wr(12, 8'h00);
		rd(12);
		chk(pd, 1);
		rd(20);
		wr(16, 8'h00);
		rd(12);
		rd(4);
		chk(pm, 0);
		stop_test;
	end
	initial begin
		#20000;
		fails++;
		stop_test;
	end
endmodule
